// File: verilog/pin_mux_defines.svh
// register offsets, field positions and reset values of the pin and block selection logic
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// ***************************************************
// register offsets
// ***************************************************
`define OFS_OUTPUT_PIN_CONTROL 8'h35
`define OFS_INPUT_PIN_CONTROL 8'h36
`define OFS_RESERVED_FIRST 8'h37
`define OFS_RESERVED_LAST 8'h3B
`define OFS_PLAYBACK_BLOCK_SELECT 8'h3C
`define OFS_RECORD_BLOCK_SELECT 8'h3D
`define OFS_RESERVED_AFTER_RECORD 8'h3E

// ***************************************************
// field positions
// ***************************************************
`define OUT_KEEPER_BIT 4
`define OUT_FUNC_MSB 3
`define OUT_FUNC_LSB 1
`define OUT_LEVEL_BIT 0
`define IN_MODE_MSB 2
`define IN_MODE_LSB 1
`define IN_LEVEL_BIT 0
`define BLOCK_SEL_MSB 4

// ***************************************************
// reset values
// ***************************************************
`define RST_OUTPUT_PIN_CONTROL 8'h12
`define RST_INPUT_PIN_CONTROL 8'h02
`define RST_PLAYBACK_BLOCK_SELECT 8'h01
`define RST_RECORD_BLOCK_SELECT 8'h04
`define RST_RESERVED 8'h00

`endif

// File: verilog/pin_mux_pkg.sv
// types shared by the pin and block selection logic
package pin_mux_pkg;

  typedef enum logic [2:0] {
    OUT_OFF,
    OUT_CODEC_DATA,
    OUT_GENERAL,
    OUT_CLOCK,
    OUT_FIRST_IRQ,
    OUT_SECOND_IRQ,
    OUT_BIT_CLOCK,
    OUT_WORD_CLOCK
  } out_func_e;

  typedef enum logic [1:0] {
    IN_OFF,
    IN_CODEC,
    IN_GENERAL,
    IN_RESERVED
  } in_mode_e;

endpackage

// File: verilog/output_pin_mux.sv
// function multiplexer and bus keeper for the serial output pin
`timescale 1ns/1ps
module output_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] func_code,
  input wire logic keeper_off,
  input wire logic general_level,
  input wire logic codec_data,
  input wire logic internal_clock_output,
  input wire logic first_interrupt_output,
  input wire logic second_interrupt_output,
  input wire logic secondary_bit_clock,
  input wire logic secondary_word_clock,
  output logic pin_out,
  output logic pin_oe_n,
  output logic keeper_active
);

  logic next_pin_out;
  logic next_pin_oe_n;
  logic next_keeper_active;

  always_comb begin
    next_pin_out = 1'b0;
    next_pin_oe_n = 1'b0;
    next_keeper_active = ~keeper_off; // RULE1
    unique case (out_func_e'(func_code))
      OUT_OFF: begin
        next_pin_out = 1'b0;
        next_pin_oe_n = 1'b1; // RULE2
      end
      OUT_CODEC_DATA: next_pin_out = codec_data; // RULE3
      OUT_GENERAL: next_pin_out = general_level; // RULE4 RULE5
      OUT_CLOCK: next_pin_out = internal_clock_output; // RULE6
      OUT_FIRST_IRQ: next_pin_out = first_interrupt_output; // RULE7
      OUT_SECOND_IRQ: next_pin_out = second_interrupt_output; // RULE7
      OUT_BIT_CLOCK: next_pin_out = secondary_bit_clock; // RULE8
      OUT_WORD_CLOCK: next_pin_out = secondary_word_clock; // RULE9
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b0;
      keeper_active <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      keeper_active <= next_keeper_active;
    end
  end

endmodule // output_pin_mux

// File: verilog/block_select_decode.sv
// decoder from a selection code to a processing block number
`timescale 1ns/1ps
module block_select_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] playback_code,
  input wire logic [4:0] record_code,
  output logic [4:0] playback_block,
  output logic playback_valid,
  output logic [4:0] record_block,
  output logic record_valid
);

  logic [4:0] next_playback_block;
  logic next_playback_valid;
  logic [4:0] next_record_block;
  logic next_record_valid;

  // block numbers equal the codes in every valid range
  function automatic logic playback_ok(input logic [4:0] code);
    playback_ok = (code >= 5'h01 && code <= 5'h04) || code == 5'h18 || code == 5'h19;
  endfunction

  function automatic logic record_ok(input logic [4:0] code);
    record_ok = (code >= 5'h04 && code <= 5'h06) || (code >= 5'h0A && code <= 5'h0C)
      || (code >= 5'h10 && code <= 5'h12);
  endfunction

  always_comb begin
    next_playback_valid = playback_ok(playback_code); // RULE14
    next_playback_block = next_playback_valid ? playback_code : 5'h00; // RULE14
    next_record_valid = record_ok(record_code); // RULE16
    next_record_block = next_record_valid ? record_code : 5'h00; // RULE16
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      playback_block <= 5'h01;
      playback_valid <= 1'b1;
      record_block <= 5'h04;
      record_valid <= 1'b1;
    end else begin
      playback_block <= next_playback_block;
      playback_valid <= next_playback_valid;
      record_block <= next_record_block;
      record_valid <= next_record_valid;
    end
  end

endmodule // block_select_decode

// File: verilog/codec_pin_mux_block_select.sv
// register file, pin control and block selection of the codec
//
// Function
// RULE1: keeper on the output pin is on when its control bit is 0.
// RULE2: output function 000 powers down the output pin buffer.
// RULE3: function 001 sends primary codec serial data to the pin.
// RULE4: function 010 makes the pin a general-purpose output.
// RULE5: general-purpose output drives the level of control bit 0.
// RULE6: function 011 puts the internal clock output on the pin.
// RULE7: codes 100 and 101 drive first and second interrupt outputs.
// RULE8: function 110 drives the secondary bit clock.
// RULE9: function 111 drives the secondary word clock.
// RULE10: input mode 00 powers down the input buffer and ignores the pin.
// RULE11: input mode 01 feeds codec data, microphone or clock generator.
// RULE12: mode 10 is general input; bit 0 reads buffer level; 11 reserved.
// RULE13: software never writes the reserved registers 0x37 to 0x3B.
// RULE14: playback block chosen from five-bit field: 1 to 4, 24, 25.
// RULE15: software avoids playback codes above 25 and writes zero only as reset.
// RULE16: record block chosen: 4 to 6, 10 to 12, 16 to 18.
// RULE17: software never writes reserved record selection codes.
// RULE18: software writes only zeros into playback select upper bits.
// RULE19: software writes only zeros to the register after record select.
// RULE20: software changes a block selection only with its converter path off.
`timescale 1ns/1ps
`include "pin_mux_defines.svh"
module codec_pin_mux_block_select
  import pin_mux_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic codec_data,
  input wire logic internal_clock_output,
  input wire logic first_interrupt_output,
  input wire logic second_interrupt_output,
  input wire logic secondary_bit_clock,
  input wire logic secondary_word_clock,
  output logic out_pin_out,
  output logic out_pin_oe_n,
  output logic out_keeper_active,
  input wire logic in_pin,
  output logic in_buffer_enable,
  output logic codec_serial_in,
  output logic general_purpose_input_mode,
  output logic [4:0] playback_block,
  output logic playback_valid,
  output logic [4:0] record_block,
  output logic record_valid
);

  // ***************************************************
  // register file
  // ***************************************************
  logic [7:0] output_pin_control;
  logic [7:0] input_pin_control;
  logic [7:0] playback_block_select;
  logic [7:0] record_block_select;
  logic [7:0] next_output_pin_control;
  logic [7:0] next_input_pin_control;
  logic [7:0] next_playback_block_select;
  logic [7:0] next_record_block_select;
  logic [7:0] next_reg_rdata;
  logic in_level;

  // buffered pin level; a powered-down buffer reads as 0
  assign in_level = in_pin & in_buffer_enable; // RULE10

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  always_comb begin
    next_output_pin_control = output_pin_control;
    next_input_pin_control = input_pin_control;
    next_playback_block_select = playback_block_select;
    next_record_block_select = record_block_select;
    // reserved offsets have no storage, so stray writes are dropped
    if (reg_write) begin // RULE13
      if (hit(reg_addr, `OFS_OUTPUT_PIN_CONTROL)) begin
        next_output_pin_control = reg_wdata;
      end
      if (hit(reg_addr, `OFS_INPUT_PIN_CONTROL)) begin
        // bit 0 is the read-only level
        next_input_pin_control = {reg_wdata[7:1], 1'b0}; // RULE12
      end
      if (hit(reg_addr, `OFS_PLAYBACK_BLOCK_SELECT)) begin
        next_playback_block_select = reg_wdata;
      end
      if (hit(reg_addr, `OFS_RECORD_BLOCK_SELECT)) begin
        next_record_block_select = reg_wdata;
      end
    end
  end

  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_read) begin
      next_reg_rdata = 8'h00;
      if (hit(reg_addr, `OFS_OUTPUT_PIN_CONTROL)) begin
        next_reg_rdata = output_pin_control;
      end
      if (hit(reg_addr, `OFS_INPUT_PIN_CONTROL)) begin
        next_reg_rdata = {input_pin_control[7:1], in_level}; // RULE12
      end
      if (hit(reg_addr, `OFS_PLAYBACK_BLOCK_SELECT)) begin
        next_reg_rdata = playback_block_select;
      end
      if (hit(reg_addr, `OFS_RECORD_BLOCK_SELECT)) begin
        next_reg_rdata = record_block_select;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_pin_control <= `RST_OUTPUT_PIN_CONTROL;
      input_pin_control <= `RST_INPUT_PIN_CONTROL;
      playback_block_select <= `RST_PLAYBACK_BLOCK_SELECT;
      record_block_select <= `RST_RECORD_BLOCK_SELECT;
      reg_rdata <= 8'h00;
    end else begin
      output_pin_control <= next_output_pin_control;
      input_pin_control <= next_input_pin_control;
      playback_block_select <= next_playback_block_select;
      record_block_select <= next_record_block_select;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ***************************************************
  // input pin mode
  // ***************************************************
  logic next_in_buffer_enable;
  logic next_codec_serial_in;
  logic next_general_purpose_input_mode;

  always_comb begin
    next_in_buffer_enable = 1'b0;
    next_codec_serial_in = 1'b0;
    next_general_purpose_input_mode = 1'b0;
    unique case (in_mode_e'(input_pin_control[`IN_MODE_MSB:`IN_MODE_LSB]))
      IN_OFF: next_in_buffer_enable = 1'b0; // RULE10
      IN_CODEC: begin
        next_in_buffer_enable = 1'b1; // RULE11
        next_codec_serial_in = in_pin; // RULE11
      end
      IN_GENERAL: begin
        next_in_buffer_enable = 1'b1; // RULE12
        next_general_purpose_input_mode = 1'b1; // RULE12
      end
      // reserved code treated as buffer off
      IN_RESERVED: next_in_buffer_enable = 1'b0; // RULE12
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_buffer_enable <= 1'b0;
      codec_serial_in <= 1'b0;
      general_purpose_input_mode <= 1'b0;
    end else begin
      in_buffer_enable <= next_in_buffer_enable;
      codec_serial_in <= next_codec_serial_in;
      general_purpose_input_mode <= next_general_purpose_input_mode;
    end
  end

  // ***************************************************
  // output pin and block selection
  // ***************************************************
  output_pin_mux u_output_pin_mux (
    .clk(clk),
    .rst(rst),
    .func_code(output_pin_control[`OUT_FUNC_MSB:`OUT_FUNC_LSB]),
    .keeper_off(output_pin_control[`OUT_KEEPER_BIT]),
    .general_level(output_pin_control[`OUT_LEVEL_BIT]),
    .codec_data(codec_data),
    .internal_clock_output(internal_clock_output),
    .first_interrupt_output(first_interrupt_output),
    .second_interrupt_output(second_interrupt_output),
    .secondary_bit_clock(secondary_bit_clock),
    .secondary_word_clock(secondary_word_clock),
    .pin_out(out_pin_out),
    .pin_oe_n(out_pin_oe_n),
    .keeper_active(out_keeper_active)
  );

  block_select_decode u_block_select_decode (
    .clk(clk),
    .rst(rst),
    .playback_code(playback_block_select[`BLOCK_SEL_MSB:0]),
    .record_code(record_block_select[`BLOCK_SEL_MSB:0]),
    .playback_block(playback_block),
    .playback_valid(playback_valid),
    .record_block(record_block),
    .record_valid(record_valid)
  );

endmodule // codec_pin_mux_block_select

// File: verification/pin_source_model.sv
// model of the codec side sources that feed the serial output pin
`timescale 1ns/1ps
module pin_source_model (
  input wire logic clk,
  input wire logic rst,
  output logic codec_data,
  output logic internal_clock_output,
  output logic first_interrupt_output,
  output logic second_interrupt_output,
  output logic secondary_bit_clock,
  output logic secondary_word_clock
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  // ****
  // pattern generator
  // ****
  always_comb begin
    next_cnt = rst ? 4'h0 : cnt + 4'h1;
  end
  always_ff @(posedge clk) begin
    cnt <= next_cnt;
  end
  // every source differs from the others, so a wrong route shows on the pin
  assign codec_data = cnt[0] ^ cnt[2];
  assign internal_clock_output = cnt[0];
  assign first_interrupt_output = cnt[1];
  assign second_interrupt_output = cnt[2];
  assign secondary_bit_clock = cnt[1] ^ cnt[3];
  assign secondary_word_clock = cnt[3];
endmodule // pin_source_model

// File: verification/codec_pin_mux_block_select_props.sv
// assertion checker for the pin and block selection logic
`timescale 1ns/1ps
module pin_mux_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic in_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic codec_data,
  input wire logic internal_clock_output,
  input wire logic first_interrupt_output,
  input wire logic second_interrupt_output,
  input wire logic secondary_bit_clock,
  input wire logic secondary_word_clock,
  input wire logic out_pin_out,
  input wire logic out_pin_oe_n,
  input wire logic out_keeper_active,
  input wire logic in_buffer_enable,
  input wire logic codec_serial_in,
  input wire logic general_purpose_input_mode,
  input wire logic playback_valid,
  input wire logic record_valid,
  input wire logic [4:0] playback_block,
  input wire logic [4:0] record_block
);
  logic [7:0] out_sh;
  logic [7:0] next_out_sh;
  logic [1:0] in_sh;
  logic [1:0] next_in_sh;
  logic [7:0] src;
  // ****
  // register shadows
  // ****
  always_comb begin
    next_out_sh = out_sh;
    next_in_sh = in_sh;
    if (reg_write && reg_addr == 8'h35) next_out_sh = reg_wdata;
    if (reg_write && reg_addr == 8'h36) next_in_sh = reg_wdata[2:1];
    if (rst) next_out_sh = 8'h12;
    if (rst) next_in_sh = 2'b01;
  end
  always_ff @(posedge clk) begin
    out_sh <= next_out_sh;
    in_sh <= next_in_sh;
  end
  assign src = {secondary_word_clock, secondary_bit_clock, second_interrupt_output,
    first_interrupt_output, internal_clock_output, out_sh[0], codec_data, 1'b0};
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // outputs lag their cause by one edge, so the first edge out of reset is skipped
  keeper_ctrl_a: assert property (!$past(rst) |-> out_keeper_active == !$past(out_sh[4]))
    else $error("keeper state wrong");
  pin_off_a: assert property (!$past(rst) |-> out_pin_oe_n == ($past(out_sh[3:1]) == 3'd0))
    else $error("output enable wrong");
  pin_route_a: assert property (!$past(rst) |-> out_pin_out == $past(src[out_sh[3:1]]))
    else $error("output pin source wrong");
  in_buffer_a: assert property (!$past(rst) |-> in_buffer_enable == ($past(in_sh) inside {2'd1, 2'd2}))
    else $error("input buffer enable wrong");
  codec_in_a: assert property (!$past(rst) |-> codec_serial_in == ($past(in_sh) == 2'd1 && $past(in_pin)))
    else $error("codec serial input wrong");
  gen_input_a: assert property (!$past(rst) |-> general_purpose_input_mode == ($past(in_sh) == 2'd2))
    else $error("general input mode wrong");
  play_block_a: assert property (playback_valid == (playback_block inside {[5'd1:5'd4], 5'd24, 5'd25}))
    else $error("playback block wrong");
  rec_block_a: assert property (record_valid == (record_block inside {[5'd4:5'd6], [5'd10:5'd12], [5'd16:5'd18]}))
    else $error("record block wrong");
  cover property (out_pin_oe_n);
  cover property (general_purpose_input_mode);
  cover property (playback_valid && playback_block == 5'd25);
  cover property (record_valid && record_block == 5'd18);
endmodule // pin_mux_props
bind codec_pin_mux_block_select pin_mux_props props_u (
  .clk(clk),
  .rst(rst),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .in_pin(in_pin),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .codec_data(codec_data),
  .internal_clock_output(internal_clock_output),
  .first_interrupt_output(first_interrupt_output),
  .second_interrupt_output(second_interrupt_output),
  .secondary_bit_clock(secondary_bit_clock),
  .secondary_word_clock(secondary_word_clock),
  .out_pin_out(out_pin_out),
  .out_pin_oe_n(out_pin_oe_n),
  .out_keeper_active(out_keeper_active),
  .in_buffer_enable(in_buffer_enable),
  .codec_serial_in(codec_serial_in),
  .general_purpose_input_mode(general_purpose_input_mode),
  .playback_valid(playback_valid),
  .record_valid(record_valid),
  .playback_block(playback_block),
  .record_block(record_block)
);

// File: verification/codec_pin_mux_block_select_tb.sv
// self-checking bench for the pin and block selection logic
`timescale 1ns/1ps
module codec_pin_mux_block_select_tb;
  logic clk, rst, reg_write, reg_read, in_pin, lv, pv, rv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic codec_data, internal_clock_output, first_interrupt_output, second_interrupt_output;
  logic secondary_bit_clock, secondary_word_clock, out_pin_out, out_pin_oe_n;
  logic out_keeper_active, in_buffer_enable, codec_serial_in, general_purpose_input_mode;
  logic [4:0] playback_block, record_block, bc;
  logic playback_valid, record_valid;
  logic [2:0] fc;
  logic [1:0] mc;
  int mismatches, compares, cycles;
  codec_pin_mux_block_select dut_u (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .codec_data(codec_data),
    .internal_clock_output(internal_clock_output),
    .first_interrupt_output(first_interrupt_output),
    .second_interrupt_output(second_interrupt_output),
    .secondary_bit_clock(secondary_bit_clock),
    .secondary_word_clock(secondary_word_clock),
    .out_pin_out(out_pin_out),
    .out_pin_oe_n(out_pin_oe_n),
    .out_keeper_active(out_keeper_active),
    .in_pin(in_pin),
    .in_buffer_enable(in_buffer_enable),
    .codec_serial_in(codec_serial_in),
    .general_purpose_input_mode(general_purpose_input_mode),
    .playback_block(playback_block),
    .playback_valid(playback_valid),
    .record_block(record_block),
    .record_valid(record_valid)
  );
  pin_source_model src_u (
    .clk(clk),
    .rst(rst),
    .codec_data(codec_data),
    .internal_clock_output(internal_clock_output),
    .first_interrupt_output(first_interrupt_output),
    .second_interrupt_output(second_interrupt_output),
    .secondary_bit_clock(secondary_bit_clock),
    .secondary_word_clock(secondary_word_clock)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****
  // access and compare tasks
  // ****
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  // derived outputs land one edge after the write
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done;
    end
  end
  // ****
  // tests
  // ****
  initial begin
    rst = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    in_pin = 1'b1;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle;
    check({out_pin_oe_n, out_keeper_active, in_buffer_enable, 5'd0}, 8'h20);
    check({2'b00, playback_valid, playback_block}, 8'h21);
    check({2'b00, record_valid, record_block}, 8'h24);
    rd(8'h35, 8'h12);
    rd(8'h36, 8'h03);
    $display("reset test done");
    for (int f = 0; f < 8; f++) begin
      fc = 3'(f);
      wr(8'h35, {3'b000, fc[1], fc, fc[0]});
      settle;
      check(8'(out_keeper_active), 8'(!fc[1]));
      check(8'(out_pin_oe_n), 8'(fc == 3'd0));
      if (fc == 3'd0) check(8'(out_pin_out), 8'h00);
      if (fc == 3'd2) check(8'(out_pin_out), 8'h00);
      rd(8'h35, {3'b000, fc[1], fc, fc[0]});
    end
    wr(8'h35, 8'h05);
    settle;
    check(8'(out_pin_out), 8'h01);
    $display("output pin test done");
    for (int m = 0; m < 8; m++) begin
      mc = 2'(m);
      lv = m > 3;
      @(posedge clk);
      in_pin <= lv;
      wr(8'h36, {5'b00000, mc, 1'b1});
      settle;
      check(8'(in_buffer_enable), 8'(mc == 2'd1 || mc == 2'd2));
      check(8'(general_purpose_input_mode), 8'(mc == 2'd2));
      check(8'(codec_serial_in), 8'(mc == 2'd1 && lv));
      rd(8'h36, {5'b00000, mc, lv && (mc == 2'd1 || mc == 2'd2)});
    end
    $display("input pin test done");
    for (int c = 0; c < 32; c++) begin
      bc = 5'(c);
      pv = bc inside {[5'd1:5'd4], 5'd24, 5'd25};
      rv = bc inside {[5'd4:5'd6], [5'd10:5'd12], [5'd16:5'd18]};
      wr(8'h3c, {3'b000, bc});
      wr(8'h3d, {3'b000, bc});
      settle;
      check({2'b00, playback_valid, playback_block}, {2'b00, pv, pv ? bc : 5'd0});
      check({2'b00, record_valid, record_block}, {2'b00, rv, rv ? bc : 5'd0});
    end
    $display("block select test done");
    for (int a = 'h37; a < 'h3f; a++) begin
      if (a < 'h3c || a == 'h3e) wr(8'(a), 8'hff);
      if (a < 'h3c || a == 'h3e) rd(8'(a), 8'h00);
    end
    wr(8'h50, 8'hff);
    rd(8'h50, 8'h00);
    rd(8'h3c, 8'h1f);
    rd(8'h3d, 8'h1f);
    $display("reserved test done");
    test_done;
  end
endmodule // codec_pin_mux_block_select_tb
